// [hw/cms_cpu_clock_mode_select.sv]
// cpu clock mode select: latches the clock mode and builds the cpu clock
// assumes one 100 MHz system clock, oscillator and pins asynchronous to it
//
// Notes on behaviour
// (RULE_01) both cpu clock edges are usable; each edge marks one phase time
// (RULE_02) mode comes from bits 7 to 5 of the config latch
// (RULE_03) long hardware reset loads the latch from port0 upper byte pins
// (RULE_04) software may reload the latch from upper reset control half
// (RULE_05) codes 111..000: x4 x3 x2 x5 direct x1.5 prescale x2.5
// (RULE_06) mode 001: prescaler, each half period is one oscillator period
// (RULE_07) mode 011: pll off, oscillator passed straight through
// (RULE_08) direct drive: two consecutive half periods make one oscillator period
// (RULE_09) pll modes multiply the input and correct frequency gradually
// (RULE_10) mode fixed between latch loads; pll is an ideal multiplier
`timescale 1ns/1ns
`default_nettype none
`include "cms_regs.svh"

module cms_cpu_clock_mode_select
  import cms_pkg::*;
#(
  parameter int PW = 16
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic i_osc,
  input wire logic i_long_reset,
  input wire logic [7:0] i_port0_upper_byte,
  input wire logic i_reset_control_load,
  input wire logic [7:0] i_reset_control_reg_hi,
  output logic o_cpu_clk,
  output logic o_phase_edge,
  output logic [7:0] o_reset_config_latch,
  output logic [2:0] o_clock_mode_select,
  output logic o_pll_active,
  output logic o_prescale_active
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic osc_s1_r, osc_s2_r, osc_s3_r;
  logic long_s1_r, long_s2_r;
  logic [7:0] port_s1_r, port_s2_r;
  logic osc_rise;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
      long_s1_r <= 1'b0;
      long_s2_r <= 1'b0;
      port_s1_r <= `CMS_RCL_RESET;
      port_s2_r <= `CMS_RCL_RESET;
    end else begin
      osc_s1_r <= i_osc;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      long_s1_r <= i_long_reset;
      long_s2_r <= long_s1_r;
      port_s1_r <= i_port0_upper_byte;
      port_s2_r <= port_s1_r;
    end
  end

  assign osc_rise = osc_s2_r & ~osc_s3_r;

  // ----------------------------------------
  // configuration latch
  // ----------------------------------------
  logic [7:0] latch_r;
  cms_mode_t mode;
  cms_mode_t mode_q_r;

  // (RULE_03) strap capture
  // (RULE_04) software reload, pins win while held
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      latch_r <= `CMS_RCL_RESET;
    end else if (long_s2_r) begin
      latch_r <= port_s2_r;
    end else if (i_reset_control_load) begin
      latch_r <= i_reset_control_reg_hi;
    end
  end

  // (RULE_02) mode field slice
  assign mode = cms_mode_t'(latch_r[`CMS_MODE_MSB:`CMS_MODE_LSB]);

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      mode_q_r <= CMS_X4;
    end else begin
      mode_q_r <= mode;
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  logic [3:0] edges;
  logic is_pll;

  // (RULE_05) factor decode
  always_comb begin
    edges = `CMS_EDGES_NONE;
    is_pll = 1'b1;
    case (mode)
      CMS_X4: edges = `CMS_EDGES_X4;
      CMS_X3: edges = `CMS_EDGES_X3;
      CMS_X2: edges = `CMS_EDGES_X2;
      CMS_X5: edges = `CMS_EDGES_X5;
      CMS_X15: edges = `CMS_EDGES_X15;
      CMS_X25: edges = `CMS_EDGES_X25;
      default: is_pll = 1'b0;
    endcase
  end

  // ----------------------------------------
  // oscillator period tracking
  // ----------------------------------------
  logic [PW-1:0] per_cnt_r, p_est_r, meas;
  logic lock_r;

  assign meas = per_cnt_r + PW'(`CMS_CNT_ONE);

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      per_cnt_r <= '0;
    end else if (osc_rise) begin
      per_cnt_r <= '0;
    end else if (per_cnt_r != '1) begin
      per_cnt_r <= meas;
    end
  end

  // (RULE_09) first lock loads, later corrections step by one
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      p_est_r <= '0;
      lock_r <= 1'b0;
    end else if (osc_rise) begin
      if (!lock_r) begin
        p_est_r <= meas;
        lock_r <= 1'b1;
      end else if (meas > p_est_r) begin
        p_est_r <= p_est_r + PW'(`CMS_CNT_ONE);
      end else if (meas < p_est_r) begin
        p_est_r <= p_est_r - PW'(`CMS_CNT_ONE);
      end
    end
  end

  // ----------------------------------------
  // ideal multiplier
  // ----------------------------------------
  // edges spread evenly by a fractional accumulator; one edge per system
  // cycle at most, so factor xN needs an oscillator period of at least 2N (edges) system cycles
  logic [PW:0] acc_r, acc_sum;
  logic pll_tick;

  assign acc_sum = acc_r + (PW+1)'(edges);
  assign pll_tick = is_pll && lock_r && (mode == mode_q_r) && (acc_sum >= {1'b0, p_est_r});

  // (RULE_10) restart phase on a mode change, outside pll modes and before lock
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      acc_r <= '0;
    end else if (mode != mode_q_r || !is_pll || !lock_r) begin
      acc_r <= '0;
    end else if (pll_tick) begin
      acc_r <= acc_sum - {1'b0, p_est_r};
    end else begin
      acc_r <= acc_sum;
    end
  end

  // ----------------------------------------
  // cpu clock generation
  // ----------------------------------------
  logic cpu_nxt;

  always_comb begin
    cpu_nxt = o_cpu_clk;
    case (mode)
      // (RULE_07) straight pass, (RULE_08) pairs sum to one period
      CMS_DIRECT: cpu_nxt = osc_s2_r;
      // (RULE_06) toggle per oscillator period
      CMS_DIV2: cpu_nxt = osc_rise ? ~o_cpu_clk : o_cpu_clk;
      // (RULE_09) multiplier edges
      default: cpu_nxt = pll_tick ? ~o_cpu_clk : o_cpu_clk;
    endcase
  end

  // (RULE_01) every edge flagged as a phase boundary
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      o_cpu_clk <= 1'b0;
      o_phase_edge <= 1'b0;
    end else begin
      o_cpu_clk <= cpu_nxt;
      o_phase_edge <= cpu_nxt ^ o_cpu_clk;
    end
  end

  // (RULE_05) status flags
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      o_pll_active <= 1'b1;
      o_prescale_active <= 1'b0;
    end else begin
      o_pll_active <= is_pll;
      o_prescale_active <= (mode == CMS_DIV2);
    end
  end

  assign o_reset_config_latch = latch_r;
  assign o_clock_mode_select = latch_r[`CMS_MODE_MSB:`CMS_MODE_LSB];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  strap_capture_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // RULE_03
    long_s2_r |=> latch_r == $past(port_s2_r))
    else $error("latch did not take port pins");

  soft_reload_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // RULE_04
    (i_reset_control_load && !long_s2_r) |=> latch_r == $past(i_reset_control_reg_hi))
    else $error("latch did not take software value");

  latch_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // RULE_10
    (!i_reset_control_load && !long_s2_r) |=> $stable(latch_r))
    else $error("latch changed without a load");

  mode_field_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // RULE_02
    ##1 o_pll_active == !($past(o_clock_mode_select) inside {CMS_DIRECT, CMS_DIV2}))
    else $error("pll flag disagrees with mode bits");

  direct_follow_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // RULE_07
    mode == CMS_DIRECT |=> o_cpu_clk == $past(osc_s2_r))
    else $error("direct drive does not follow oscillator");

  prescale_toggle_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // RULE_06
    mode == CMS_DIV2 |=> (o_cpu_clk != $past(o_cpu_clk)) == $past(osc_rise))
    else $error("prescaler edge not tied to oscillator rise");

  phase_edge_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // RULE_01
    ##1 o_phase_edge == (o_cpu_clk != $past(o_cpu_clk)))
    else $error("phase edge pulse misplaced");

  gradual_step_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // RULE_09
    (lock_r && $past(lock_r)) |-> (p_est_r == $past(p_est_r) ||
      p_est_r == $past(p_est_r) + PW'(`CMS_CNT_ONE) ||
      p_est_r == $past(p_est_r) - PW'(`CMS_CNT_ONE)))
    else $error("period estimate jumped");

  x4_default_a: assert property (@(posedge I_SYS_CLK) // RULE_05
    I_RST |=> o_clock_mode_select == CMS_X4 && o_pll_active)
    else $error("reset mode is not x4");

endmodule
`default_nettype wire

// [include/cms_pkg.sv]
// types for the cpu clock mode select block
// assumes nothing beyond a systemverilog compiler
package cms_pkg;

  typedef enum logic [2:0] {
    CMS_X25 = 3'b000,
    CMS_DIV2 = 3'b001,
    CMS_X15 = 3'b010,
    CMS_DIRECT = 3'b011,
    CMS_X5 = 3'b100,
    CMS_X2 = 3'b101,
    CMS_X3 = 3'b110,
    CMS_X4 = 3'b111
  } cms_mode_t;

endpackage

// [include/cms_regs.svh]
// constants for the cpu clock mode select block
// assumes inclusion by bare name from the design file
`ifndef CMS_REGS_SVH
`define CMS_REGS_SVH

// ----------------------------------------
// configuration latch layout
// ----------------------------------------
`define CMS_MODE_MSB 7
`define CMS_MODE_LSB 5
`define CMS_RCL_RESET 8'hff

// ----------------------------------------
// pll model
// ----------------------------------------
// cpu edges per oscillator period (twice the factor)
`define CMS_EDGES_X4 4'h8
`define CMS_EDGES_X3 4'h6
`define CMS_EDGES_X2 4'h4
`define CMS_EDGES_X5 4'ha
`define CMS_EDGES_X15 4'h3
`define CMS_EDGES_X25 4'h5
`define CMS_EDGES_NONE 4'h0
`define CMS_CNT_ONE 1

`endif

// [sim/cms_cpu_clock_mode_select_tb.sv]
// bench for the cpu clock mode select block
// assumes the package and the oscillator model are compiled first
`timescale 1ns/1ns
`default_nettype none
module cms_cpu_clock_mode_select_tb;
  import cms_pkg::*;
  logic I_SYS_CLK = 1'b0, I_RST = 1'b1;
  logic long_rst = 1'b0, sw_ld = 1'b0, osc_en = 1'b0;
  logic [7:0] port_hi = 8'hff, rc_hi = 8'h00, latch;
  logic [15:0] hi_ns = 16'h001e, lo_ns = 16'h0032;
  logic osc, cpu_clk, edge_p, pll_on, pre_on;
  logic [2:0] mode;
  int failures = 0, check_count = 0, cyc = 0, edges = 0;
  time ta, tb, tc;
  always #5 I_SYS_CLK = ~I_SYS_CLK;
  // offset keeps oscillator edges away from sampling edges
  initial #2 osc_en = 1'b1;
  cms_osc_model u_cms_osc_model (.i_en(osc_en), .i_high_ns(hi_ns), .i_low_ns(lo_ns),
    .o_osc(osc));
  cms_cpu_clock_mode_select u_cms_cpu_clock_mode_select (.I_SYS_CLK(I_SYS_CLK),
    .I_RST(I_RST), .i_osc(osc), .i_long_reset(long_rst), .i_port0_upper_byte(port_hi),
    .i_reset_control_load(sw_ld), .i_reset_control_reg_hi(rc_hi), .o_cpu_clk(cpu_clk),
    .o_phase_edge(edge_p), .o_reset_config_latch(latch), .o_clock_mode_select(mode),
    .o_pll_active(pll_on), .o_prescale_active(pre_on));
  always @(posedge I_SYS_CLK) begin
    cyc++;
    if (edge_p === 1'b1) edges++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sw_load(input logic [7:0] v);
    @(negedge I_SYS_CLK);
    sw_ld = 1'b1;
    rc_hi = v;
    @(negedge I_SYS_CLK);
    sw_ld = 1'b0;
    @(negedge I_SYS_CLK);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    check(latch, 8'hff);
    check({mode, pll_on, pre_on, cpu_clk}, 6'h3c);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      sw_load({m[2:0], 5'h0a});
      check(latch, {m[2:0], 5'h0a});
      check(mode, m[2:0]);
      check(pll_on, m != 1 && m != 3);
      check(pre_on, m == 1);
    end
  endtask
  task automatic t_long;
    port_hi = 8'h35;
    long_rst = 1'b1;
    repeat (4) @(negedge I_SYS_CLK);
    // software reload must lose against a held long reset
    sw_load(8'hea);
    check(latch, 8'h35);
    check(mode, 3'b001);
    long_rst = 1'b0;
    repeat (6) @(negedge I_SYS_CLK);
    port_hi = 8'hc0;
    repeat (6) @(negedge I_SYS_CLK);
    check(latch, 8'h35);
  endtask
  task automatic t_shape(input logic [2:0] m, input int ehi, input int eper, input int epp);
    sw_load({m, 5'h00});
    repeat (40) @(negedge I_SYS_CLK);
    edges = 0;
    repeat (80) @(negedge I_SYS_CLK);
    check(edges, 10 * epp);
    @(posedge cpu_clk);
    ta = $time;
    @(negedge cpu_clk);
    tb = $time;
    @(posedge cpu_clk);
    tc = $time;
    check(32'(tb - ta), ehi);
    check(32'(tc - ta), eper);
  endtask
  task automatic t_pll;
    logic [2:0] ms [6] = '{3'b111, 3'b110, 3'b101, 3'b100, 3'b010, 3'b000};
    int ep [6] = '{8, 6, 4, 10, 3, 5};
    for (int i = 0; i < 6; i++) begin
      sw_load({ms[i], 5'h1f});
      repeat (400) @(negedge I_SYS_CLK);
      edges = 0;
      repeat (200) @(negedge I_SYS_CLK);
      // fractional accumulator may slip one edge at the window ends
      check(edges >= 10 * ep[i] - 2 && edges <= 10 * ep[i] + 2, 1);
      check(mode, ms[i]);
    end
  endtask
  initial begin
    repeat (2) @(negedge I_SYS_CLK);
    I_RST = 1'b0;
    repeat (3) @(negedge I_SYS_CLK);
    t_reset();
    t_modes();
    t_long();
    t_shape(3'b001, 80, 160, 1);
    t_shape(3'b011, 30, 80, 2);
    hi_ns = 16'h0064;
    lo_ns = 16'h0064;
    t_pll();
    wrap_up();
  end
endmodule
`default_nettype wire

// [sim/cms_osc_model.sv]
// oscillator source for the clock mode select bench
// assumes the bench sets high and low times in ns
`timescale 1ns/1ns
`default_nettype none
module cms_osc_model (
  input wire logic i_en,
  input wire logic [15:0] i_high_ns,
  input wire logic [15:0] i_low_ns,
  output logic o_osc
);
  // free running once enabled, as a crystal would be
  initial begin
    o_osc = 1'b0;
    forever begin
      wait (i_en);
      o_osc = 1'b1;
      #(i_high_ns);
      o_osc = 1'b0;
      #(i_low_ns);
    end
  end
endmodule
`default_nettype wire
